// ### design/eci_ctrl.sv
// Interrupt, self-test and receive-acceptance control with AXI4-Lite registers
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module eci_ctrl
  import eci_pkg::*;
(
  // Clock and reset
  input  wire logic              i_ref_clk,
  input  wire logic              i_rst_n,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Pins
  input  wire logic              i_carrier,
  input  wire logic              i_dma_tc,
  output logic                   o_irq,
  output logic                   o_loopback_n,
  // Transmitter
  input  wire logic              i_tx_req,
  input  wire logic              i_tx_start,
  input  wire logic              i_tx_byte,
  input  wire logic              i_tx_coll,
  input  wire logic              i_tx_done,
  input  wire logic [3:0]        i_tx_hdr_ie,
  output logic                   o_tx_go,
  output logic                   o_tx_abort,
  output logic                   o_crc_corrupt,
  // Receiver
  input  wire logic              i_rx_sof,
  input  wire logic              i_rx_end,
  input  wire logic              i_rx_mode_ok,
  input  wire logic              i_rx_dest_ok,
  input  wire logic              i_rx_crc_err,
  input  wire logic              i_rx_short,
  input  wire logic              i_rx_dribble,
  input  wire logic              i_rx_pre_coll,
  output logic                   o_rx_en,
  output logic                   o_crc_keep,
  output logic                   o_rx_store,
  output logic                   o_rx_discard,
  output logic                   o_rx_trunc
);
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic [DATA_W-1:0] wmask;
  logic [DATA_W-1:0] cw;
  logic              wr_en;
  logic              cmd_wr;
  logic              cfg_wr;
  logic              wr_hit;
  logic [2:0]        ie_q;
  logic [2:0]        on_q;
  logic [2:0]        cmd_on;
  logic [2:0]        cmd_off;
  logic [2:0]        cmd_ack;
  logic [2:0]        flag_set;
  logic [2:0]        flags;
  logic [15:0]       cfg2_q;
  logic [1:0]        car_sync_q;
  logic [1:0]        tc_sync_q;
  logic              tc_prev_q;
  logic              car_prev_q;
  logic              in_frame_q;
  logic              car_drop;
  logic              rx_event;
  logic [4:0]        coll_cnt;
  logic [3:0]        tx_ev;
  logic [DATA_W-1:0] rd_mux;
  logic              rd_hit;
  logic              rx_err;
  logic              rx_ok_addr;

  // Write channel: address and data taken in any order, then one response
  assign wr_en  = !o_awready && !o_wready && !o_bvalid;
  assign wmask  = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
  assign cw     = wdata_q & wmask;
  assign cmd_wr = wr_en && (awaddr_q == ADDR_CMD);
  assign cfg_wr = wr_en && (awaddr_q == ADDR_CFG2);
  assign wr_hit = (awaddr_q == ADDR_CMD) || (awaddr_q == ADDR_CFG2) || (awaddr_q == ADDR_STAT);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= 4'h0;
    end
    else
    begin
      if (o_awready && i_awvalid)
      begin
        o_awready <= 1'b0;
        awaddr_q  <= i_awaddr;
      end
      if (o_wready && i_wvalid)
      begin
        o_wready <= 1'b0;
        wdata_q  <= i_wdata;
        wstrb_q  <= i_wstrb;
      end
      if (wr_en)
      begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? RESP_OKAY : RESP_SLV;
      end
      else if (o_bvalid && i_bready)
      begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // Strobe fields exist only in the written word, never in storage
  assign cmd_on  = cmd_wr ? cw[CMD_ON_LSB +: 3]  : 3'b000;
  assign cmd_off = cmd_wr ? cw[CMD_OFF_LSB +: 3] : 3'b000;
  assign cmd_ack = cmd_wr ? cw[CMD_ACK_LSB +: 3] : 3'b000;

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ie_q <= 3'b000;
    else if (cmd_wr)
      ie_q <= (ie_q & ~wmask[CMD_IE_LSB +: 3]) | cw[CMD_IE_LSB +: 3];
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cfg2_q <= CFG2_RST;
    else if (cfg_wr)
      cfg2_q <= (cfg2_q & ~wmask[15:0]) | cw[15:0];
  end

  // Both on and off together leave the function state alone
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      on_q <= 3'b000;
    else
      on_q <= (on_q | (cmd_on & ~cmd_off)) & ~(cmd_off & ~cmd_on);
  end

  // Pin inputs pass two flops; edges are taken after the second
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      car_sync_q <= 2'b00;
      tc_sync_q  <= 2'b00;
      car_prev_q <= 1'b0;
      tc_prev_q  <= 1'b0;
    end
    else
    begin
      car_sync_q <= {car_sync_q[0], i_carrier};
      tc_sync_q  <= {tc_sync_q[0], i_dma_tc};
      car_prev_q <= car_sync_q[1];
      tc_prev_q  <= tc_sync_q[1];
    end
  end

  eci_tx_track u_tx_track (
    .i_ref_clk  (i_ref_clk),
    .i_rst_n    (i_rst_n),
    .i_start    (i_tx_start),
    .i_byte     (i_tx_byte),
    .i_coll     (i_tx_coll),
    .i_done     (i_tx_done),
    .o_coll_cnt (coll_cnt),
    .o_ev       (tx_ev),
    .o_abort    (o_tx_abort)
  );

  // Receive acceptance
  assign car_drop   = in_frame_q && car_prev_q && !car_sync_q[1] && !i_rx_end;
  assign rx_ok_addr = cfg2_q[CFG_STA_EN] && i_rx_mode_ok && i_rx_dest_ok;
  assign rx_err     = (i_rx_crc_err && !cfg2_q[CFG_ACC_CRC])
                   || (i_rx_short && !cfg2_q[CFG_ACC_SH])
                   || (i_rx_dribble && !cfg2_q[CFG_ACC_DR]);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      in_frame_q <= 1'b0;
    else if (i_rx_sof && on_q[FN_RX])
      in_frame_q <= 1'b1;
    else if (i_rx_end || car_drop)
      in_frame_q <= 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_rx_store   <= 1'b0;
      o_rx_discard <= 1'b0;
      o_rx_trunc   <= 1'b0;
    end
    else
    begin
      o_rx_trunc <= car_drop && rx_ok_addr && cfg2_q[CFG_ACC_SH] && !i_rx_pre_coll;
      o_rx_store <= in_frame_q && i_rx_end && rx_ok_addr && !rx_err && !i_rx_pre_coll;
      o_rx_discard <= in_frame_q && (i_rx_end || car_drop)
                   && (!rx_ok_addr || i_rx_pre_coll
                   || (i_rx_end && rx_err) || (car_drop && !cfg2_q[CFG_ACC_SH]));
    end
  end

  assign rx_event = o_rx_store || o_rx_trunc;

  // Interrupt flags
  assign flag_set[FN_DMA] = (tc_sync_q[1] && !tc_prev_q) || (cmd_on[FN_DMA] && cmd_off[FN_DMA]);
  assign flag_set[FN_RX]  = rx_event || (cmd_on[FN_RX] && cmd_off[FN_RX]);
  assign flag_set[FN_TX]  = |(tx_ev & i_tx_hdr_ie) || (cmd_on[FN_TX] && cmd_off[FN_TX]);

  eci_flag u_flag_dma (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (flag_set[FN_DMA]),
    .i_clr     (cmd_ack[FN_DMA]),
    .o_flag    (flags[FN_DMA])
  );

  // Set beats clear so a packet landing during acknowledge is not lost
  eci_flag u_flag_rx (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (flag_set[FN_RX]),
    .i_clr     (cmd_ack[FN_RX]),
    .o_flag    (flags[FN_RX])
  );

  eci_flag u_flag_tx (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (flag_set[FN_TX]),
    .i_clr     (cmd_ack[FN_TX]),
    .o_flag    (flags[FN_TX])
  );

  // Outputs registered; the interrupt trails its flag by one cycle
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_irq         <= 1'b0;
      o_loopback_n  <= 1'b1;
      o_crc_corrupt <= 1'b0;
      o_crc_keep    <= 1'b0;
      o_rx_en       <= 1'b0;
      o_tx_go       <= 1'b0;
    end
    else
    begin
      o_irq         <= |(flags & ie_q);
      o_loopback_n  <= !cfg2_q[CFG_LOOP];
      o_crc_corrupt <= cfg2_q[CFG_CRC_BAD];
      o_crc_keep    <= cfg2_q[CFG_CRC_KEEP];
      o_rx_en       <= on_q[FN_RX];
      o_tx_go       <= i_tx_req && on_q[FN_TX] && !car_sync_q[1] && !in_frame_q;
    end
  end

  // Read channel
  always_comb
  begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (i_araddr)
      ADDR_STAT:
      begin
        rd_mux[ST_DMA_BIT]       = flags[FN_DMA];
        rd_mux[ST_RX_BIT]        = flags[FN_RX];
        rd_mux[ST_TX_BIT]        = flags[FN_TX];
        rd_mux[ST_ON_LSB +: 3]   = on_q;
        rd_mux[ST_COLL_LSB +: 5] = coll_cnt;
      end
      ADDR_CMD:  rd_mux[CMD_IE_LSB +: 3] = ie_q;
      ADDR_CFG2: rd_mux[15:0] = cfg2_q;
      default:   rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end
    else if (o_arready && i_arvalid)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_mux;
      o_rresp   <= rd_hit ? RESP_OKAY : RESP_SLV;
    end
    else if (o_rvalid && i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end
endmodule : eci_ctrl

// ### design/eci_pkg.sv
// Constants shared by the interrupt and diagnostic block
package eci_pkg;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam logic [7:0]  ADDR_STAT  = 8'h00;
  localparam logic [7:0]  ADDR_CMD   = 8'h04;
  localparam logic [7:0]  ADDR_CFG2  = 8'h08;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLV   = 2'h2;
  // Function index used for flags, enables and on/off state
  localparam int          FN_DMA     = 0;
  localparam int          FN_RX      = 1;
  localparam int          FN_TX      = 2;
  // Command register
  localparam int          CMD_IE_LSB  = 0;
  localparam int          CMD_ACK_LSB = 4;
  localparam int          CMD_ON_LSB  = 8;
  localparam int          CMD_OFF_LSB = 11;
  // Status register
  localparam int          ST_DMA_BIT  = 3;
  localparam int          ST_TX_BIT   = 4;
  localparam int          ST_RX_BIT   = 5;
  localparam int          ST_ON_LSB   = 8;
  localparam int          ST_COLL_LSB = 12;
  // Second configuration register
  localparam int          CFG_STA_EN  = 2;
  localparam int          CFG_ACC_SH  = 3;
  localparam int          CFG_ACC_DR  = 4;
  localparam int          CFG_ACC_CRC = 5;
  localparam int          CFG_CRC_BAD = 9;
  localparam int          CFG_CRC_KEEP = 10;
  localparam int          CFG_LOOP    = 11;
  localparam logic [15:0] CFG2_RST    = 16'h0000;
  // Transmit event index, as enabled by the packet header
  localparam int          EV_BABBLE   = 0;
  localparam int          EV_COLL     = 1;
  localparam int          EV_COLL16   = 2;
  localparam int          EV_OK       = 3;
  localparam logic [4:0]  MAX_COLL    = 5'd16;
  localparam logic [10:0] MAX_LEN     = 11'd1514;
endpackage : eci_pkg

// ### design/eci_flag.sv
// Sticky status flag where a set beats a simultaneous clear
`timescale 1ns/1ps
module eci_flag (
  // Clock and reset
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  // Control
  input  wire logic i_set,
  input  wire logic i_clr,
  // State
  output logic      o_flag
);
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_flag <= 1'b0;
    else if (i_set)
      o_flag <= 1'b1;
    else if (i_clr)
      o_flag <= 1'b0;
  end
endmodule : eci_flag

// ### design/eci_tx_track.sv
// Per-packet collision and length tracking with transmit events
`timescale 1ns/1ps
module eci_tx_track
  import eci_pkg::*;
(
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  // Transmitter strobes
  input  wire logic        i_start,
  input  wire logic        i_byte,
  input  wire logic        i_coll,
  input  wire logic        i_done,
  // Results
  output logic [4:0]       o_coll_cnt,
  output logic [3:0]       o_ev,
  output logic             o_abort
);
  logic [10:0] len_q;
  logic        last_coll;

  assign last_coll = i_coll && (o_coll_cnt == MAX_COLL - 5'd1);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_coll_cnt <= 5'd0;
    else if (i_start)
      o_coll_cnt <= 5'd0;
    else if (i_coll && o_coll_cnt != MAX_COLL)
      o_coll_cnt <= o_coll_cnt + 5'd1;
  end

  // Saturates so a huge frame cannot wrap back under the limit
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      len_q <= 11'd0;
    else if (i_start)
      len_q <= 11'd0;
    else if (i_byte && len_q != 11'h7FF)
      len_q <= len_q + 11'd1;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_ev    <= 4'h0;
      o_abort <= 1'b0;
    end
    else
    begin
      o_ev[EV_COLL]   <= i_coll;
      o_ev[EV_COLL16] <= last_coll;
      o_abort         <= last_coll;
      o_ev[EV_OK]     <= i_done && (o_coll_cnt < MAX_COLL);
      o_ev[EV_BABBLE] <= i_done && (len_q > MAX_LEN);
    end
  end
endmodule : eci_tx_track

// ### testbench/eci_ctrl_props.sv
// Port checker for the interrupt and diagnostic block
`timescale 1ns/1ps
module eci_ctrl_props (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Bus and pins
  input wire logic o_bvalid,
  input wire logic o_loopback_n,
  input wire logic o_crc_corrupt,
  input wire logic o_crc_keep,
  input wire logic o_irq,
  // Transmitter
  input wire logic i_tx_start,
  input wire logic i_tx_coll,
  input wire logic o_tx_go,
  input wire logic o_tx_abort,
  // Receiver
  input wire logic i_rx_sof,
  input wire logic i_rx_end,
  input wire logic i_rx_mode_ok,
  input wire logic i_rx_dest_ok,
  input wire logic i_rx_pre_coll,
  input wire logic o_rx_en,
  input wire logic o_rx_store,
  input wire logic o_rx_discard
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);
  logic [4:0] coll_q;
  logic       in_rx_q;
  // Own collision count, so the abort moment is judged independently
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      coll_q <= 5'h00;
    else if (i_tx_start)
      coll_q <= 5'h00;
    else if (i_tx_coll && coll_q != 5'h10)
      coll_q <= coll_q + 5'h01;
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
    if (!i_rst_n)
      in_rx_q <= 1'b0;
    else if (i_rx_end)
      in_rx_q <= 1'b0;
    else if (i_rx_sof && o_rx_en)
      in_rx_q <= 1'b1;
  a_abort_at_16: assert property (i_tx_coll && !i_tx_start && coll_q == 5'h0F |=> o_tx_abort)
    else $error("Missing abort");
  a_abort_cause: assert property (o_tx_abort |-> $past(i_tx_coll) && $past(coll_q) == 5'h0F)
    else $error("Stray abort");
  a_abort_single: assert property (o_tx_abort |=> !o_tx_abort)
    else $error("Abort too long");
  a_go_rx_idle: assert property (in_rx_q && $past(in_rx_q) |-> !$rose(o_tx_go))
    else $error("Transmit allowed in frame");
  a_precoll_drop: assert property (in_rx_q && i_rx_end && i_rx_pre_coll |=> o_rx_discard && !o_rx_store)
    else $error("Preamble collision frame kept");
  a_store_clean: assert property (o_rx_store |-> !$past(i_rx_pre_coll))
    else $error("Store after preamble collision");
  a_store_match: assert property (o_rx_store && $past(i_rx_end) |-> $past(i_rx_mode_ok && i_rx_dest_ok))
    else $error("Store without match");
  a_loop_by_write: assert property ($changed(o_loopback_n) |-> o_bvalid || $past(o_bvalid))
    else $error("Loopback moved without write");
  a_diag_by_write: assert property ($changed({o_crc_corrupt, o_crc_keep}) |-> o_bvalid || $past(o_bvalid))
    else $error("Diagnostic moved without write");
  c_abort: cover property (o_tx_abort);
  c_store: cover property (o_rx_store);
  c_irq: cover property ($rose(o_irq));
endmodule : eci_ctrl_props
bind eci_ctrl eci_ctrl_props eci_ctrl_props_i (.*);

// ### testbench/eci_dma_model.sv
// Terminal-count source standing in for the external DMA controller
`timescale 1ns/1ps
module eci_dma_model (
  // Clock and trigger
  input  wire logic i_ref_clk,
  input  wire logic i_go,
  // Terminal count
  output logic      o_tc
);
  logic [2:0] hold_q = 3'h0;
  // Held several cycles so the two-flop synchroniser cannot miss it
  always_ff @(posedge i_ref_clk)
    hold_q <= i_go ? 3'h5 : ((hold_q != 3'h0) ? hold_q - 3'h1 : 3'h0);
  assign o_tc = (hold_q != 3'h0);
endmodule : eci_dma_model

// ### testbench/eci_ctrl_tb_top.sv
// Self-checking bench for the interrupt and diagnostic block
`timescale 1ns/1ps
module eci_ctrl_tb_top
  import eci_pkg::*;
;
  logic              i_ref_clk = '0, i_rst_n = '0, i_carrier = '0, i_tx_req = '0;
  logic [ADDR_W-1:0] i_awaddr = '0, i_araddr = '0;
  logic [DATA_W-1:0] i_wdata = '0, o_rdata, d;
  logic [3:0]        i_wstrb = 4'hF, i_tx_hdr_ie = '0;
  logic              i_awvalid = '0, i_wvalid = '0, i_bready = '0, i_arvalid = '0, i_rready = '0;
  logic              i_rx_mode_ok = '0, i_rx_dest_ok = '0, i_rx_crc_err = '0, i_rx_pre_coll = '0;
  logic              i_rx_short = '0, i_rx_dribble = '0, i_dma_tc;
  logic              o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq, o_loopback_n;
  logic              o_tx_go, o_tx_abort, o_crc_corrupt, o_rx_en, o_crc_keep, o_rx_store, o_rx_discard, o_rx_trunc;
  logic [1:0]        o_bresp, o_rresp, br, r;
  logic [6:0]        st = '0;
  wire               i_tx_start = st[0], i_tx_byte = st[1], i_tx_coll = st[2], i_tx_done = st[3];
  wire               i_rx_sof = st[4], i_rx_end = st[5], i_dma_go = st[6];
  int                fails = 0, cmp_count = 0, ev_n[4] = '{0, 0, 0, 0}, sn[4];
  logic [3:0]        lv_t [5] = '{4'h1, 4'h2, 4'h7, 4'h7, 4'hB};
  logic [31:0]       cf_t [5] = '{32'h4, 32'h4, 32'h4, 32'h24, 32'h24};
  int                k_t [5] = '{1, 1, 1, 2, 1};
  logic [3:0]        ie_t [4] = '{4'h1, 4'h1, 4'h8, 4'h8};
  int                by_t [4] = '{1514, 1515, 0, 0}, co_t [4] = '{0, 0, 15, 16};
  logic              irq_t [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
  eci_ctrl eci_ctrl_i (.*);
  eci_dma_model eci_dma_model_i (.i_ref_clk(i_ref_clk), .i_go(i_dma_go), .o_tc(i_dma_tc));
  always #25 i_ref_clk = ~i_ref_clk;
  // Event counters: pulses stand one cycle, so they are caught at every edge
  always @(posedge i_ref_clk)
  begin
    ev_n[0] += o_tx_abort;
    ev_n[1] += o_rx_discard;
    ev_n[2] += o_rx_store;
    ev_n[3] += o_rx_trunc;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test
  task automatic tick(input int n);
    repeat (n) @(posedge i_ref_clk);
  endtask : tick
  task automatic tmo();
    fails++;
    $display("Error at %0t: bus timeout", $time);
    finish_test();
  endtask : tmo
  task strobe(input int k, input int n);
    repeat (n)
    begin
      @(posedge i_ref_clk);
      st[k] <= 1'b1;
      @(posedge i_ref_clk);
      st[k] <= 1'b0;
    end
  endtask : strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge i_ref_clk);
    i_awaddr <= a;
    i_wdata <= v;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_ref_clk);
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (o_bvalid) break;
    end
    i_bready <= 1'b0;
    br = o_bresp;
    if (n == 50) tmo();
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge i_ref_clk);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge i_ref_clk);
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (o_rvalid) break;
    end
    i_rready <= 1'b0;
    d = o_rdata;
    r = o_rresp;
    if (n == 50) tmo();
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    check(d & m, e);
  endtask : rchk
  task automatic evd(input int k, input int e);
    check(ev_n[k] - sn[k], e);
  endtask : evd
  task automatic frame(input logic [3:0] lv);
    sn = ev_n;
    strobe(4, 1);
    tick(3);
    {i_rx_pre_coll, i_rx_crc_err, i_rx_dest_ok, i_rx_mode_ok} <= lv;
    strobe(5, 1);
    tick(4);
    {i_rx_pre_coll, i_rx_crc_err, i_rx_dest_ok, i_rx_mode_ok} <= 4'h0;
  endtask : frame
  task automatic tx_pkt(input int by, input int co);
    sn = ev_n;
    strobe(0, 1);
    strobe(2, co);
    strobe(1, by);
    strobe(3, 1);
    tick(4);
  endtask : tx_pkt
  // Status bit that holds each function's interrupt flag
  function automatic int fb(input int f);
    return (f == FN_RX) ? ST_RX_BIT : ((f == FN_TX) ? ST_TX_BIT : ST_DMA_BIT);
  endfunction : fb
  initial
  begin
    int f;
    tick(8);
    i_rst_n <= 1'b1;
    tick(1);
    check({o_loopback_n, o_irq}, 2'b10);
    wr(ADDR_CFG2, 32'h0000_0E00);
    tick(2);
    check({o_loopback_n, o_crc_corrupt, o_crc_keep}, 3'b011);
    rchk(ADDR_CFG2, 32'h0000_FFFF, 32'h0000_0E00);
    wr(ADDR_CFG2, 32'h0000_0000);
    tick(2);
    check({o_loopback_n, o_crc_corrupt, o_crc_keep}, 3'b100);
    wr(8'h0C, 32'h0000_0001);
    check(br, RESP_SLV);
    rd(8'h0C);
    check(r, RESP_SLV);
    check(d, 32'h0);
    for (f = 0; f < 3; f++)
    begin
      wr(ADDR_CMD, (32'h1 << (CMD_ON_LSB + f)) | (32'h1 << (CMD_OFF_LSB + f)));
      tick(3);
      check(o_irq, 1'b0);
      rchk(ADDR_STAT, 32'h1 << fb(f), 32'h1 << fb(f));
      wr(ADDR_CMD, 32'h1 << f);
      tick(3);
      check(o_irq, 1'b1);
      rchk(ADDR_CMD, 32'h0000_3FFF, 32'h1 << f);
      wr(ADDR_CMD, (32'h1 << f) | (32'h1 << (CMD_ACK_LSB + f)));
      tick(3);
      check(o_irq, 1'b0);
      rchk(ADDR_STAT, 32'h1 << fb(f), 32'h0);
    end
    wr(ADDR_CMD, 32'h1);
    strobe(6, 1);
    tick(10);
    check(o_irq, 1'b1);
    rchk(ADDR_STAT, 32'h8, 32'h8);
    wr(ADDR_CMD, 32'h11);
    tick(3);
    check(o_irq, 1'b0);
    wr(ADDR_CFG2, 32'h4);
    wr(ADDR_CMD, 32'h202);
    frame(4'h3);
    evd(2, 1);
    check(o_irq, 1'b1);
    rchk(ADDR_STAT, 32'h20, 32'h20);
    tick(200);
    check(o_irq, 1'b1);
    // Host acknowledges 200 cycles after the stored frame, with no following frame arriving meanwhile
    wr(ADDR_CMD, 32'h222);
    tick(3);
    check(o_irq, 1'b0);
    for (f = 0; f < 5; f++)
    begin
      wr(ADDR_CFG2, cf_t[f]);
      frame(lv_t[f]);
      evd(k_t[f], 1);
    end
    wr(ADDR_CMD, 32'h1202);
    tick(2);
    check(o_rx_en, 1'b1);
    frame(4'h3);
    evd(2, 1);
    wr(ADDR_CFG2, 32'hC);
    sn = ev_n;
    i_carrier <= 1'b1;
    {i_rx_dest_ok, i_rx_mode_ok} <= 2'b11;
    strobe(4, 1);
    tick(4);
    i_carrier <= 1'b0;
    tick(8);
    check(ev_n[3] - sn[3], 32'h1);
    check(ev_n[2] - sn[2], 32'h0);
    strobe(5, 1);
    {i_rx_dest_ok, i_rx_mode_ok} <= 2'b00;
    wr(ADDR_CMD, 32'h404);
    i_tx_req <= 1'b1;
    tick(4);
    check(o_tx_go, 1'b1);
    i_tx_hdr_ie <= 4'h4;
    tx_pkt(0, 16);
    evd(0, 1);
    check(o_irq, 1'b1);
    wr(ADDR_CMD, 32'h444);
    for (f = 0; f < 4; f++)
    begin
      i_tx_hdr_ie <= ie_t[f];
      tx_pkt(by_t[f], co_t[f]);
      check(o_irq, irq_t[f]);
      wr(ADDR_CMD, 32'h444);
    end
    strobe(4, 1);
    tick(4);
    check(o_tx_go, 1'b0);
    strobe(5, 1);
    tick(4);
    finish_test();
  end
endmodule : eci_ctrl_tb_top
